// file: logic/mbf_defs.svh
// Timing, code and reset constants for the serial-line framer
`ifndef MBF_DEFS_SVH
`define MBF_DEFS_SVH

`define MBF_CLK_HZ 100000000
`define MBF_CHAR_BITS 11
// Silent-interval figures in units of 100 us, per baud code 0..6
`define MBF_T35_2400_100US 161
`define MBF_T35_4800_100US 81
`define MBF_T35_9600_100US 41
`define MBF_T35_19200_100US 21
`define MBF_T35_38400_100US 11
`define MBF_T35_57600_100US 7
`define MBF_T35_115200_100US 4
`define MBF_CYC_PER_100US (`MBF_CLK_HZ / 10000)
`define MBF_CYC_PER_MS (`MBF_CLK_HZ / 1000)
`define MBF_WAIT_MS_MAX 99
`define MBF_WAIT_MS_RST 20
`define MBF_ADDR_BCAST 8'h00
`define MBF_ADDR_MAX 8'hf7
`define MBF_EXC_FLAG 8'h80
`define MBF_CRC_POLY 16'ha001
`define MBF_CRC_INIT 16'hffff
`define MBF_EXC_ILL_FUNC 8'h01
`define MBF_FC_RD_HOLD 8'h03
`define MBF_FC_RD_INPUT 8'h04
`define MBF_FC_WR_SINGLE 8'h06
`define MBF_FC_WR_MULTI 8'h10
`define MBF_FC_RW_MULTI 8'h17

`endif

// file: logic/mbf_pkg.sv
// Types shared by the framer modules
package mbf_pkg;
	// One byte with its strobe
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} mbf_byte_t;

	// Request header handed to the PDU layer
	typedef struct packed {
		logic bcast;
		logic [7:0] addr;
		logic [7:0] func;
	} mbf_hdr_t;

	typedef enum logic [2:0] {
		MBF_IDLE = 3'b000,
		MBF_RECV = 3'b001,
		MBF_PROC = 3'b010,
		MBF_WAIT = 3'b011,
		MBF_SEND = 3'b100,
		MBF_CRCL = 3'b101,
		MBF_CRCH = 3'b110,
		MBF_GAP = 3'b111
	} mbf_state_t;
endpackage : mbf_pkg

// file: logic/mbf_crc16.sv
// Byte-wide reflected CRC-16 engine
`timescale 1ns/1ps
`include "mbf_defs.svh"
module mbf_crc16 (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic init,
	input wire logic en,
	input wire logic [7:0] din,
	// Result
	output logic [15:0] crc
);
	import mbf_pkg::*;

	logic [15:0] step [0:8];

	// Eight shift steps per byte, LSB first, polynomial folded in when bit falls out
	assign step[0] = crc ^ {8'h00, din};
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			assign step[i+1] = step[i][0] ? ((step[i] >> 1) ^ `MBF_CRC_POLY) : (step[i] >> 1);
		end
	endgenerate

	// Init wins over update so a new frame never inherits old state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crc <= `MBF_CRC_INIT;
		end else if (init) begin
			crc <= `MBF_CRC_INIT;
		end else if (en) begin
			crc <= step[8];
		end
	end
endmodule : mbf_crc16

// file: logic/mbf_framer.sv
// Serial-line RTU server framer: gap framing, address filter, CRC, response sequencing
`timescale 1ns/1ps
`include "mbf_defs.svh"
module mbf_framer #(
	parameter int WAIT_CYC_PER_MS = `MBF_CYC_PER_MS,
	parameter int GAP_CYC_PER_100US = `MBF_CYC_PER_100US
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration (static levels from the instrument)
	input wire logic [7:0] own_addr,
	input wire logic [2:0] baud_sel,
	input wire logic [6:0] wait_ms,
	// Received characters from the UART layer (same clock)
	input wire mbf_pkg::mbf_byte_t rx_byte,
	input wire logic rx_err,
	// Request stream to the PDU layer
	output mbf_pkg::mbf_byte_t req_byte,
	output mbf_pkg::mbf_hdr_t req_hdr,
	output logic req_start,
	output logic req_end,
	// Processing result from the PDU layer
	input wire logic proc_done,
	input wire logic proc_exc,
	input wire logic [7:0] proc_exc_code,
	// Response data bytes from the PDU layer, big-endian order
	input wire mbf_pkg::mbf_byte_t rsp_byte,
	input wire logic rsp_last,
	output logic rsp_ready,
	// Transmit characters to the UART layer
	output mbf_pkg::mbf_byte_t tx_byte,
	input wire logic tx_ready,
	output logic tx_busy
);
	import mbf_pkg::*;

	localparam int GAP_W = 24;
	mbf_state_t state_r;
	logic [GAP_W-1:0] gap_cnt_r;
	logic [GAP_W-1:0] gap_lim;
	logic [GAP_W-1:0] wait_lim;
	logic [GAP_W-1:0] wait_cnt_r;
	logic gap_done;
	logic [7:0] hold_r [0:1];
	logic [1:0] hold_n_r;
	logic [2:0] idx_r;
	logic [7:0] addr_r;
	logic [7:0] func_r;
	logic accept_r;
	logic bcast_r;
	logic err_r;
	logic exc_r;
	logic [7:0] exc_code_r;
	logic rsp_end_r;
	logic crc_init;
	logic crc_en;
	logic [7:0] crc_din;
	logic [15:0] crc;
	logic rx_go;
	logic tx_go;
	logic [6:0] wait_clip;
	logic fc_ok;

	// Silent threshold per baud code; figures already carry 3.5 x 11 bit periods
	// No fixed 1.75 ms floor is applied at any rate
	always_comb begin
		unique case (baud_sel)
			3'd0: gap_lim = GAP_W'(`MBF_T35_2400_100US * GAP_CYC_PER_100US);
			3'd1: gap_lim = GAP_W'(`MBF_T35_4800_100US * GAP_CYC_PER_100US);
			3'd2: gap_lim = GAP_W'(`MBF_T35_9600_100US * GAP_CYC_PER_100US);
			3'd3: gap_lim = GAP_W'(`MBF_T35_19200_100US * GAP_CYC_PER_100US);
			3'd4: gap_lim = GAP_W'(`MBF_T35_38400_100US * GAP_CYC_PER_100US);
			3'd5: gap_lim = GAP_W'(`MBF_T35_57600_100US * GAP_CYC_PER_100US);
			default: gap_lim = GAP_W'(`MBF_T35_115200_100US * GAP_CYC_PER_100US);
		endcase
	end

	// Waiting time clipped to its legal range
	assign wait_clip = (wait_ms > 7'(`MBF_WAIT_MS_MAX)) ? 7'(`MBF_WAIT_MS_MAX) : wait_ms;
	assign wait_lim = GAP_W'(wait_clip) * GAP_W'(WAIT_CYC_PER_MS);
	assign gap_done = (gap_cnt_r >= gap_lim);

	// Only 16-bit register codes pass
	assign fc_ok = (func_r == `MBF_FC_RD_HOLD) || (func_r == `MBF_FC_RD_INPUT) ||
		(func_r == `MBF_FC_WR_SINGLE) || (func_r == `MBF_FC_WR_MULTI) ||
		(func_r == `MBF_FC_RW_MULTI);

	// Silence counter: restarted by every character in either direction; saturates
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_cnt_r <= '0;
		end else if (rx_byte.valid || tx_go) begin
			gap_cnt_r <= '0;
		end else if (!gap_done) begin
			gap_cnt_r <= gap_cnt_r + GAP_W'(1);
		end
	end

	// Receive acceptance; characters inside a frame never time out before T3.5
	assign rx_go = rx_byte.valid && (state_r == MBF_IDLE || state_r == MBF_RECV);
	assign tx_go = tx_byte.valid && tx_ready;

	// Main sequence
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= MBF_GAP;
			wait_cnt_r <= '0;
			exc_r <= 1'b0;
			exc_code_r <= 8'h00;
			rsp_end_r <= 1'b0;
		end else begin
			unique case (state_r)
				MBF_GAP: begin
					// Start gap must elapse before any frame is believed
					if (gap_done) begin
						state_r <= MBF_IDLE;
					end
				end
				MBF_IDLE: begin
					if (rx_byte.valid) begin
						state_r <= MBF_RECV;
					end
				end
				MBF_RECV: begin
					// Frame ends on T3.5 silence
					if (gap_done) begin
						if (!accept_r || err_r || idx_r < 3'd4 || crc != 16'h0000) begin
							state_r <= MBF_IDLE; // Bad CRC, foreign or short frame: drop
						end else if (!fc_ok) begin
							exc_r <= 1'b1;
							exc_code_r <= `MBF_EXC_ILL_FUNC;
							state_r <= bcast_r ? MBF_IDLE : MBF_WAIT;
							wait_cnt_r <= '0;
						end else begin
							exc_r <= 1'b0;
							state_r <= MBF_PROC;
						end
					end
				end
				MBF_PROC: begin
					// Answer only after processing has finished
					if (proc_done) begin
						exc_r <= proc_exc; // Address and size faults arrive here
						exc_code_r <= proc_exc_code;
						wait_cnt_r <= '0;
						state_r <= bcast_r ? MBF_IDLE : MBF_WAIT;
					end
				end
				MBF_WAIT: begin
					// Response held off for the waiting time
					if (wait_cnt_r >= wait_lim) begin
						state_r <= MBF_SEND;
						rsp_end_r <= 1'b0;
					end else begin
						wait_cnt_r <= wait_cnt_r + GAP_W'(1);
					end
				end
				MBF_SEND: begin
					// Last byte marked when it is loaded: exception code or final body byte
					if (tx_go && rsp_end_r) begin
						state_r <= MBF_CRCL;
					end else if ((tx_idx_r == 2'd1 && tx_go && exc_r) ||
						(rsp_ready && rsp_byte.valid && rsp_last)) begin
						rsp_end_r <= 1'b1;
					end
				end
				MBF_CRCL: begin
					if (tx_go) begin
						state_r <= MBF_CRCH; // Low CRC byte first
					end
				end
				MBF_CRCH: begin
					if (tx_go) begin
						state_r <= MBF_GAP; // End gap before listening again
					end
				end
				default: state_r <= MBF_GAP;
			endcase
		end
	end

	// Receive byte index, header capture, address filter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idx_r <= 3'd0;
			addr_r <= 8'h00;
			func_r <= 8'h00;
			accept_r <= 1'b0;
			bcast_r <= 1'b0;
			err_r <= 1'b0;
		end else if (rx_go) begin
			if (state_r == MBF_IDLE) begin
				idx_r <= 3'd1;
				addr_r <= rx_byte.data;
				bcast_r <= (rx_byte.data == `MBF_ADDR_BCAST);
				accept_r <= (rx_byte.data == `MBF_ADDR_BCAST) ||
					(rx_byte.data == own_addr && rx_byte.data <= `MBF_ADDR_MAX);
				err_r <= rx_err; // Character fault poisons the frame
			end else begin
				if (idx_r == 3'd1) begin
					func_r <= rx_byte.data;
				end
				if (idx_r != 3'd7) begin
					idx_r <= idx_r + 3'd1;
				end
				err_r <= err_r | rx_err;
			end
		end
	end

	// Two-byte delay line so CRC bytes never reach the PDU layer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_r[0] <= 8'h00;
			hold_r[1] <= 8'h00;
			hold_n_r <= 2'd0;
		end else if (state_r == MBF_IDLE) begin
			hold_n_r <= 2'd0;
		end else if (rx_go && idx_r >= 3'd2) begin
			hold_r[0] <= rx_byte.data;
			hold_r[1] <= hold_r[0];
			if (hold_n_r != 2'd2) begin
				hold_n_r <= hold_n_r + 2'd1;
			end
		end
	end

	// Request stream: header at frame end once the CRC checks, data bytes with two-byte lag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_byte <= '0;
			req_hdr <= '0;
			req_start <= 1'b0;
			req_end <= 1'b0;
		end else begin
			req_byte.valid <= rx_go && accept_r && idx_r >= 3'd2 && hold_n_r == 2'd2;
			req_byte.data <= hold_r[1];
			req_start <= state_r == MBF_RECV && gap_done && accept_r && !err_r &&
				idx_r >= 3'd4 && crc == 16'h0000 && fc_ok;
			req_end <= 1'b0;
			req_hdr <= '{bcast: bcast_r, addr: addr_r, func: func_r};
		end
	end

	// CRC engine shared by receive check and transmit generation
	assign crc_init = (state_r == MBF_IDLE && !rx_byte.valid) || (state_r == MBF_WAIT);
	assign crc_en = rx_go || (tx_go && state_r == MBF_SEND);
	assign crc_din = rx_go ? rx_byte.data : tx_byte.data;

	mbf_crc16 u_crc (
		.clk(clk),
		.rst(rst),
		.init(crc_init),
		.en(crc_en),
		.din(crc_din),
		.crc(crc)
	);

	// Transmit byte counter for header fields
	logic [1:0] tx_idx_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_idx_r <= 2'd0;
		end else if (state_r != MBF_SEND) begin
			tx_idx_r <= 2'd0;
		end else if (tx_go && tx_idx_r != 2'd2) begin
			tx_idx_r <= tx_idx_r + 2'd1;
		end
	end

	// Transmit data: address, function (+0x80 on exception), body, CRC low then high
	// Body bytes pass in the PDU layer's big-endian order untouched
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_byte <= '0;
		end else begin
			tx_byte.valid <= 1'b0;
			if (state_r == MBF_SEND && !(tx_go && rsp_end_r)) begin
				tx_byte.valid <= 1'b1;
				if (tx_idx_r == 2'd0 && !tx_go) begin
					tx_byte.data <= addr_r;
				end else if ((tx_idx_r == 2'd0 && tx_go) || (tx_idx_r == 2'd1 && !tx_go)) begin
					tx_byte.data <= exc_r ? (func_r | `MBF_EXC_FLAG) : func_r;
				end else if (exc_r) begin
					tx_byte.data <= exc_code_r;
				end else if (rsp_ready) begin
					tx_byte.data <= rsp_byte.data;
					tx_byte.valid <= rsp_byte.valid;
				end else begin
					// A body byte still waiting for the UART keeps its place
					tx_byte.valid <= tx_byte.valid;
				end
			end else if (state_r == MBF_CRCL) begin
				// CRC read one cycle late so it already covers the last body byte
				tx_byte.valid <= 1'b1;
				tx_byte.data <= tx_go ? crc[15:8] : crc[7:0];
			end else if (state_r == MBF_CRCH) begin
				tx_byte.valid <= !tx_go;
			end
		end
	end

	// Body bytes taken from the PDU layer once the header is out
	// Taken when the transmit register is free to load the next body byte
	assign rsp_ready = state_r == MBF_SEND && !exc_r && !rsp_end_r &&
		((tx_idx_r == 2'd1 && tx_go) || (tx_idx_r == 2'd2 && (tx_go || !tx_byte.valid)));
	assign tx_busy = state_r == MBF_SEND || state_r == MBF_CRCL || state_r == MBF_CRCH;
endmodule : mbf_framer

// file: verif/mbf_framer_chk.sv
// Port-level assertions for the serial framer
`timescale 1ns/1ps
module mbf_framer_chk #(
	parameter int WAIT_CYC_PER_MS = 10,
	parameter int GAP_CYC_PER_100US = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration
	input wire logic [7:0] own_addr,
	input wire logic [2:0] baud_sel,
	input wire logic [6:0] wait_ms,
	// Receive and request side
	input wire mbf_pkg::mbf_byte_t rx_byte,
	input wire mbf_pkg::mbf_hdr_t req_hdr,
	input wire logic req_start,
	input wire logic proc_done,
	input wire logic proc_exc,
	input wire logic rsp_ready,
	// Transmit side
	input wire mbf_pkg::mbf_byte_t tx_byte,
	input wire logic tx_ready,
	input wire logic tx_busy
);
	import mbf_pkg::*;
	// Silent interval per baud code in 100 us units
	localparam int T35_TAB [7] = '{161, 81, 41, 21, 11, 7, 4};
	int t35;
	int wcyc;
	logic [15:0] idle_r;
	logic [15:0] done_r;
	logic [3:0] idx_r;
	logic hdr_r;
	logic fin_r;
	logic exc_r;
	assign t35 = T35_TAB[baud_sel] * GAP_CYC_PER_100US;
	assign wcyc = (wait_ms > 7'h63 ? 99 : int'(wait_ms)) * WAIT_CYC_PER_MS;
	// Silence since the last character, saturating so long idles stay legal
	always_ff @(posedge clk or posedge rst)
		if (rst) idle_r <= '0;
		else if (rx_byte.valid) idle_r <= '0;
		else if (idle_r != 16'hffff) idle_r <= idle_r + 16'h1;
	// Time since processing ended
	always_ff @(posedge clk or posedge rst)
		if (rst) done_r <= '0;
		else if (proc_done) done_r <= '0;
		else if (done_r != 16'hffff) done_r <= done_r + 16'h1;
	// Per-request flags, cleared by the next incoming character
	always_ff @(posedge clk or posedge rst)
		if (rst) {hdr_r, fin_r, exc_r} <= '0;
		else if (rx_byte.valid) {hdr_r, fin_r, exc_r} <= '0;
		else begin
			if (req_start) hdr_r <= 1'b1;
			if (proc_done) {fin_r, exc_r} <= {1'b1, proc_exc};
		end
	// Position of the next byte within the reply
	always_ff @(posedge clk or posedge rst)
		if (rst) idx_r <= '0;
		else if (rx_byte.valid) idx_r <= '0;
		else if (tx_byte.valid && tx_ready && idx_r != 4'hf) idx_r <= idx_r + 4'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	gap_before_req_a: assert property (req_start |-> idle_r >= t35)
		else $error("request released before a full silence");
	reply_hold_a: assert property ($rose(tx_byte.valid) && fin_r && idx_r == 4'h0
		|-> done_r >= wcyc - 1) else $error("reply started inside the waiting time");
	addr_filter_a: assert property (req_start |-> (req_hdr.bcast ?
		req_hdr.addr == 8'h00 : req_hdr.addr == own_addr)) else $error("foreign frame passed");
	func_set_a: assert property (req_start |-> req_hdr.func inside
		{8'h03, 8'h04, 8'h06, 8'h10, 8'h17}) else $error("unsupported code passed");
	bcast_quiet_a: assert property (hdr_r && req_hdr.bcast |-> !tx_byte.valid)
		else $error("reply to a broadcast");
	tx_hold_a: assert property (tx_byte.valid && !tx_ready |=>
		tx_byte.valid && $stable(tx_byte.data)) else $error("transmit byte not held");
	echo_addr_a: assert property (hdr_r && tx_byte.valid && idx_r == 4'h0 |->
		tx_byte.data == req_hdr.addr) else $error("reply address differs");
	echo_func_a: assert property (hdr_r && fin_r && tx_byte.valid && idx_r == 4'h1 |->
		tx_byte.data == (req_hdr.func | (exc_r ? 8'h80 : 8'h00))) else $error("bad reply code");
	pull_in_reply_a: assert property (rsp_ready |-> tx_busy && fin_r)
		else $error("body taken outside a reply");
endmodule : mbf_framer_chk

// file: verif/mbf_client.sv
// Client-side character model: sends request characters, takes reply characters
`timescale 1ns/1ps
module mbf_client (
	// Clock
	input wire logic clk,
	// Characters toward the framer
	output mbf_pkg::mbf_byte_t rx_byte,
	output logic rx_err,
	// Characters from the framer
	input wire mbf_pkg::mbf_byte_t tx_byte,
	output logic tx_ready
);
	import mbf_pkg::*;
	initial begin
		rx_byte = '{valid: 1'b0, data: 8'h5a};
		rx_err = 1'b0;
		tx_ready = 1'b1;
	end
	// Random stalls: the far side is not obliged to drain at once
	always @(negedge clk) tx_ready <= ($urandom % 3) != 0;
	// Reflected CRC over a byte list, as the client computes it
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction : crc16
	// One character; the data lines stop showing it once it is gone
	task automatic send_char(input logic [7:0] b, input logic err, input int gap);
		@(negedge clk);
		rx_byte <= '{valid: 1'b1, data: b};
		rx_err <= err;
		@(negedge clk);
		rx_byte <= '{valid: 1'b0, data: ~b};
		rx_err <= 1'b0;
		repeat (gap) @(negedge clk);
	endtask : send_char
	// Whole request: bytes, CRC low then high, then a full end silence
	task automatic send_frame(input logic [7:0] q[$], input logic [1:0] bad, input int gap);
		logic [15:0] c;
		c = crc16(q) ^ {15'h0, bad[0]};
		foreach (q[i]) send_char(q[i], bad[1] && i == 1, gap);
		send_char(c[7:0], 1'b0, gap);
		send_char(c[15:8], 1'b0, gap);
		repeat (16) @(negedge clk);
	endtask : send_frame
endmodule : mbf_client

// file: verif/mbf_framer_tb.sv
// Self-checking bench for the framer with a client model and a processing stand-in
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module mbf_framer_tb;
	import mbf_pkg::*;
	logic clk, rst, rx_err, req_start, req_end, proc_done, proc_exc, rsp_last, rsp_ready;
	logic tx_ready, tx_busy, got_req;
	logic [7:0] own_addr, proc_exc_code, e8;
	logic [15:0] r16;
	mbf_byte_t rx_byte, req_byte, rsp_byte, tx_byte;
	mbf_hdr_t req_hdr, eh;
	logic [7:0] tx_q[$];
	logic [7:0] dat_q[$];
	mbf_hdr_t hdr_q[$];
	int n_mismatch, check_count, cyc;
	mbf_framer #(.WAIT_CYC_PER_MS(10), .GAP_CYC_PER_100US(2)) dut (.clk(clk), .rst(rst),
		.own_addr(own_addr), .baud_sel(3'h6), .wait_ms(7'h2), .rx_byte(rx_byte),
		.rx_err(rx_err), .req_byte(req_byte), .req_hdr(req_hdr), .req_start(req_start),
		.req_end(req_end), .proc_done(proc_done), .proc_exc(proc_exc),
		.proc_exc_code(proc_exc_code), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
		.rsp_ready(rsp_ready), .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_busy(tx_busy));
	mbf_client cli (.clk(clk), .rx_byte(rx_byte), .rx_err(rx_err), .tx_byte(tx_byte),
		.tx_ready(tx_ready));
	always #5 clk = ~clk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// A hang costs a mismatch; the full run needs about a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// Every result is matched against the oldest note; an unnoted one meets an unknown
	always @(posedge clk) if (!rst) begin
		if (tx_byte.valid && tx_ready) begin
			e8 = tx_q.size() ? tx_q.pop_front() : 8'hxx;
			`CHK("tx_byte", e8, tx_byte.data)
		end
		if (req_start) begin
			got_req = 1'b1;
			eh = hdr_q.size() ? hdr_q.pop_front() : 'x;
			`CHK("req_hdr", eh, req_hdr)
		end
		if (req_byte.valid) begin
			e8 = dat_q.size() ? dat_q.pop_front() : 8'hxx;
			`CHK("req_byte", e8, req_byte.data)
		end
	end
	// One request, its notes, the processing stand-in and the wait for the reply
	task automatic run(input logic [7:0] a, input logic [7:0] f, input int nd,
		input int gap, input logic [1:0] bad, input logic [7:0] xc, input int nr);
		logic [7:0] d[$];
		logic [7:0] r[$];
		logic [7:0] t[$];
		logic [15:0] c;
		logic ok;
		logic sup;
		int n;
		ok = bad == 2'b00 && (a == own_addr || a == 8'h00);
		sup = f inside {8'h03, 8'h04, 8'h06, 8'h10, 8'h17};
		d.push_back(a);
		d.push_back(f);
		repeat (nd) d.push_back(8'($urandom));
		repeat (nr) r.push_back(8'($urandom));
		// Data bytes stream out before the CRC is known; only the header waits for it
		if (a == own_addr || a == 8'h00) begin
			for (int i = 2; i < d.size(); i++) dat_q.push_back(d[i]);
		end
		if (ok && sup) begin
			hdr_q.push_back('{bcast: a == 8'h00, addr: a, func: f});
		end
		if (ok && a != 8'h00) begin
			t.push_back(a);
			t.push_back(sup && xc == 8'h00 ? f : f | 8'h80);
			if (!sup) t.push_back(8'h01);
			else if (xc != 8'h00) t.push_back(xc);
			else foreach (r[i]) t.push_back(r[i]);
			c = cli.crc16(t);
			t.push_back(c[7:0]);
			t.push_back(c[15:8]);
			foreach (t[i]) tx_q.push_back(t[i]);
		end
		got_req = 1'b0;
		cli.send_frame(d, bad, gap);
		if (ok && sup) begin
			for (n = 0; !got_req && n < 100; n++) @(negedge clk);
			proc_done <= 1'b1;
			proc_exc <= xc != 8'h00;
			proc_exc_code <= xc;
			@(negedge clk);
			proc_done <= 1'b0;
			proc_exc <= 1'b0;
			foreach (r[i]) begin
				rsp_byte <= '{valid: 1'b1, data: r[i]};
				rsp_last <= i == r.size() - 1;
				for (n = 0; n < 400; n++) begin
					@(posedge clk);
					if (rsp_ready) break;
				end
				@(negedge clk);
			end
			rsp_byte <= '{valid: 1'b0, data: ~rsp_byte.data};
			rsp_last <= 1'b0;
		end
		for (n = 0; (tx_q.size() != 0 || tx_busy) && n < 800; n++) @(negedge clk);
		repeat (16) @(negedge clk);
	endtask : run
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		got_req = 1'b0;
		own_addr = 8'h11;
		proc_done = 1'b0;
		proc_exc = 1'b0;
		proc_exc_code = 8'h00;
		rsp_byte = '0;
		rsp_last = 1'b0;
		void'($urandom(23768));
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (20) @(negedge clk);
		r16 = cli.crc16('{8'h01, 8'h04, 8'h00, 8'h01, 8'h00, 8'h03});
		`CHK("crc_ref", 16'hcbe1, r16)
		run(8'h11, 8'h04, 4, 5, 2'b00, 8'h00, 8); // Slow characters, one frame
		run(8'h11, 8'h03, 4, 0, 2'b00, 8'h00, 4);
		run(8'h11, 8'h06, 4, 0, 2'b00, 8'h00, 4);
		run(8'h11, 8'h10, 9, 0, 2'b00, 8'h00, 4);
		run(8'h11, 8'h17, 10, 0, 2'b00, 8'h00, 6);
		run(8'h11, 8'h03, 4, 0, 2'b00, 8'h02, 0);
		run(8'h11, 8'h10, 6, 0, 2'b00, 8'h03, 0);
		run(8'h11, 8'h05, 4, 0, 2'b00, 8'h00, 0);
		run(8'h11, 8'h04, 4, 0, 2'b01, 8'h00, 2);
		run(8'h11, 8'h04, 4, 0, 2'b10, 8'h00, 2);
		run(8'h00, 8'h06, 4, 0, 2'b00, 8'h00, 0);
		run(8'h12, 8'h04, 4, 0, 2'b00, 8'h00, 2);
		run(8'hf8, 8'h04, 4, 0, 2'b00, 8'h00, 2);
		own_addr = 8'hf7;
		run(8'hf7, 8'h04, 4, 0, 2'b00, 8'h00, 4);
		`CHK("leftover", 0, tx_q.size() + hdr_q.size() + dat_q.size())
		report_and_stop();
	end
endmodule : mbf_framer_tb
bind mbf_framer mbf_framer_chk #(.WAIT_CYC_PER_MS(WAIT_CYC_PER_MS),
	.GAP_CYC_PER_100US(GAP_CYC_PER_100US)) u_chk (.clk(clk), .rst(rst),
	.own_addr(own_addr), .baud_sel(baud_sel), .wait_ms(wait_ms), .rx_byte(rx_byte),
	.req_hdr(req_hdr), .req_start(req_start), .proc_done(proc_done), .proc_exc(proc_exc),
	.rsp_ready(rsp_ready), .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_busy(tx_busy));
